// [verilog/wwd_pkg.sv]
`default_nettype none
package wwd_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    // pin strap state of the programming pins
    typedef enum logic [1:0] {
        WWD_PIN_CAP  = 2'h0,
        WWD_PIN_PULL = 2'h1,
        WWD_PIN_OPEN = 2'h2
    } wwd_pin_e;
    // watchdog state machine, gray along the usual path
    typedef enum logic [1:0] {
        WWD_ST_STARTUP = 2'h0,
        WWD_ST_WATCH   = 2'h1,
        WWD_ST_TIMEOUT = 2'h3,
        WWD_ST_OFF     = 2'h2
    } wwd_state_e;
    typedef struct packed {
        logic     sel0;
        logic     sel1;
        wwd_pin_e timeout_pin;
        wwd_pin_e delay_pin;
    } wwd_cfg_s;
    // apb register map
    localparam logic [11:0] WWD_CTRL_OFS   = 12'h000;
    localparam logic [11:0] WWD_STATUS_OFS = 12'h004;
    localparam logic [11:0] WWD_CNT_OFS    = 12'h008;
    localparam logic [31:0] WWD_CTRL_RST   = 32'h0000_0000;
    localparam int unsigned WWD_CTRL_SEL0_BIT = 0;
    localparam int unsigned WWD_CTRL_SEL1_BIT = 1;
    localparam int unsigned WWD_CTRL_TPIN_LSB = 4;
    localparam int unsigned WWD_CTRL_DPIN_LSB = 8;
    localparam int unsigned WWD_CW = 24;
endpackage : wwd_pkg
`default_nettype wire

// [verilog/wwd_top.sv]
// Overview of operation
// - kicks ignored until startup reset delay ends
// - kicks ignored while timeout output low
// - kicks ignored while watchdog disabled
// - select pins plus timeout pin pick window
// - timeout from capacitor value or preset
// - reset delay from capacitor value or preset
// - timeout output low exactly reset delay unless disabled during the pulse
// - disabled watchdog keeps timeout output high
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module wwd_top #(
    parameter int unsigned CW         = 24,
    // capacitor programmed values, in cycles
    parameter int unsigned CAP_UPPER  = 400_000,
    parameter int unsigned CAP_LOWER  = 50_000,
    parameter int unsigned CAP_DELAY  = 200_000,
    // preset values, in cycles
    parameter int unsigned PRE_UPPER  = 40_000,
    parameter int unsigned PRE_LOWER  = 5_000,
    parameter int unsigned PULL_UPPER = 80_000,
    parameter int unsigned PULL_LOWER = 10_000,
    parameter int unsigned OPEN_DELAY = 8_000,
    parameter int unsigned PULL_DELAY = 16_000
) (
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // watchdog pins
    input  wire logic               kick_input,
    output logic                    timeout_output_n
);
    import wwd_pkg::*;

    ////////////////////////////////////////////////////////////////////
    logic [31:0]      ctrl_reg;
    wwd_cfg_s         cfg;
    wwd_state_e       state_reg;
    logic [CW-1:0]    cnt_reg;
    logic             kick_d_reg;
    logic             early_reg;
    logic             late_reg;
    logic [CW-1:0]    upper_t;
    logic [CW-1:0]    lower_t;
    logic [CW-1:0]    delay_t;
    logic             disabled;
    logic             kick_fall;
    logic             wr_en;
    logic             rd_en;
    logic             addr_ok;

    ////////////////////////////////////////////////////////////////////
    // apb: zero wait states, unmapped address answers pslverr
    assign pready = 1'b1;
    assign wr_en  = psel && penable && pwrite;
    assign rd_en  = psel && penable && !pwrite;
    always_comb begin
        if (paddr == WWD_CTRL_OFS) begin
            addr_ok = 1'b1;
        end else if (paddr == WWD_STATUS_OFS) begin
            addr_ok = 1'b1;
        end else if (paddr == WWD_CNT_OFS) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end
    assign pslverr = psel && penable && !addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= WWD_CTRL_RST;
        end else if (wr_en && paddr == WWD_CTRL_OFS) begin
            ctrl_reg <= {20'h0_0000, pwdata[11:0] & 12'h333};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == WWD_CTRL_OFS) begin
                prdata <= ctrl_reg;
            end else if (paddr == WWD_STATUS_OFS) begin
                prdata <= {26'h000_0000, late_reg, early_reg,
                           disabled, !timeout_output_n, state_reg};
            end else if (paddr == WWD_CNT_OFS) begin
                prdata <= {{(32-CW){1'b0}}, cnt_reg};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // strap decode
    assign cfg.sel0        = ctrl_reg[WWD_CTRL_SEL0_BIT];
    assign cfg.sel1        = ctrl_reg[WWD_CTRL_SEL1_BIT];
    assign cfg.timeout_pin = wwd_pin_e'(ctrl_reg[WWD_CTRL_TPIN_LSB +: 2]);
    assign cfg.delay_pin   = wwd_pin_e'(ctrl_reg[WWD_CTRL_DPIN_LSB +: 2]);

    // sel 01 disables; numeric tables not modelled, ratios scale presets
    always_comb begin
        disabled = (cfg.sel1 == 1'b0) && (cfg.sel0 == 1'b1);
        case (cfg.timeout_pin)
            WWD_PIN_CAP: begin
                upper_t = CW'(CAP_UPPER);
                lower_t = CW'(CAP_LOWER);
            end
            WWD_PIN_PULL: begin
                upper_t = CW'(PULL_UPPER);
                lower_t = CW'(PULL_LOWER);
            end
            default: begin
                upper_t = CW'(PRE_UPPER);
                lower_t = CW'(PRE_LOWER);
            end
        endcase
        if (cfg.sel1) begin
            lower_t = lower_t >> (cfg.sel0 ? 2 : 1);
        end
        case (cfg.delay_pin)
            WWD_PIN_CAP:  delay_t = CW'(CAP_DELAY);
            WWD_PIN_PULL: delay_t = CW'(PULL_DELAY);
            default:      delay_t = CW'(OPEN_DELAY);
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // kick edge; kick_input taken as synchronous
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kick_d_reg <= 1'b1;
        end else begin
            kick_d_reg <= kick_input;
        end
    end
    assign kick_fall = kick_d_reg && !kick_input;

    ////////////////////////////////////////////////////////////////////
    // watchdog state machine, times as cycle counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= WWD_ST_STARTUP;
            cnt_reg   <= '0;
        end else begin
            case (state_reg)
                WWD_ST_STARTUP: begin
                    // kicks ignored during power-up delay
                    if (cnt_reg + 1'b1 >= delay_t) begin
                        state_reg <= disabled ? WWD_ST_OFF : WWD_ST_WATCH;
                        cnt_reg   <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                WWD_ST_WATCH: begin
                    if (disabled) begin
                        state_reg <= WWD_ST_OFF;
                        cnt_reg   <= '0;
                    end else if (kick_fall && cnt_reg < lower_t) begin
                        state_reg <= WWD_ST_TIMEOUT;
                        cnt_reg   <= '0;
                    end else if (kick_fall) begin
                        cnt_reg <= '0;
                    end else if (cnt_reg + 1'b1 >= upper_t) begin
                        state_reg <= WWD_ST_TIMEOUT;
                        cnt_reg   <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                WWD_ST_TIMEOUT: begin
                    // kick ignored here; disable ends the pulse early
                    if (disabled) begin
                        state_reg <= WWD_ST_OFF;
                        cnt_reg   <= '0;
                    end else if (cnt_reg + 1'b1 >= delay_t) begin
                        state_reg <= WWD_ST_WATCH;
                        cnt_reg   <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                default: begin
                    cnt_reg <= '0;
                    if (!disabled) begin
                        state_reg <= WWD_ST_WATCH;
                    end
                end
            endcase
        end
    end

    // sticky cause flags, replaced by the new cause when the next timeout starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            early_reg <= 1'b0;
            late_reg  <= 1'b0;
        end else if (state_reg == WWD_ST_WATCH && !disabled) begin
            if (kick_fall && cnt_reg < lower_t) begin
                early_reg <= 1'b1;
                late_reg  <= 1'b0;
            end else if (!kick_fall && cnt_reg + 1'b1 >= upper_t) begin
                early_reg <= 1'b0;
                late_reg  <= 1'b1;
            end
        end
    end

    assign timeout_output_n = (state_reg != WWD_ST_TIMEOUT);

    ////////////////////////////////////////////////////////////////////
    property p_early_kick;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == WWD_ST_WATCH && !disabled && kick_fall
         && cnt_reg < lower_t) |=> !timeout_output_n;
    endproperty
    a_early_kick: assert property (p_early_kick)
        else $error("early kick did not cause timeout");

    property p_disabled_high;
        @(posedge pclk) disable iff (!presetn)
        disabled && $past(disabled) |-> timeout_output_n;
    endproperty
    a_disabled_high: assert property (p_disabled_high)
        else $error("output low while disabled");

    property p_startup_ignore;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == WWD_ST_STARTUP) |=> timeout_output_n;
    endproperty
    a_startup_ignore: assert property (p_startup_ignore)
        else $error("timeout during startup delay");

    property p_timeout_kick;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == WWD_ST_TIMEOUT && cnt_reg + 1'b1 < delay_t
         && !disabled) |=> (state_reg == WWD_ST_TIMEOUT);
    endproperty
    a_timeout_kick: assert property (p_timeout_kick)
        else $error("timeout pulse ended early");

    property p_timeout_len;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == WWD_ST_TIMEOUT && cnt_reg + 1'b1 >= delay_t
         && !disabled) |=> timeout_output_n;
    endproperty
    a_timeout_len: assert property (p_timeout_len)
        else $error("timeout pulse too long");

    property p_disable_ignore;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == WWD_ST_OFF && disabled) |=> (cnt_reg == '0);
    endproperty
    a_disable_ignore: assert property (p_disable_ignore)
        else $error("counter moved while disabled");

    property p_late;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == WWD_ST_WATCH && !disabled && !kick_fall
         && cnt_reg + 1'b1 >= upper_t) |=> !timeout_output_n;
    endproperty
    a_late: assert property (p_late)
        else $error("missing kick did not time out");

    property p_select;
        @(posedge pclk) disable iff (!presetn)
        (cfg.sel1 && cfg.sel0) |-> (lower_t <= upper_t);
    endproperty
    a_select: assert property (p_select)
        else $error("window bounds inverted");

    property p_delay_sel;
        @(posedge pclk) disable iff (!presetn)
        (cfg.delay_pin == WWD_PIN_PULL) |-> (delay_t == CW'(PULL_DELAY));
    endproperty
    a_delay_sel: assert property (p_delay_sel)
        else $error("wrong reset delay selected");

    property p_startup_kick;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == WWD_ST_STARTUP && kick_fall
         && cnt_reg + 1'b1 < delay_t) |=> (state_reg == WWD_ST_STARTUP);
    endproperty
    a_startup_kick: assert property (p_startup_kick)
        else $error("kick acted during startup delay");

    property p_timeout_ignore;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == WWD_ST_TIMEOUT && kick_fall && !disabled
         && cnt_reg + 1'b1 < delay_t) |=> (cnt_reg == $past(cnt_reg) + 1'b1);
    endproperty
    a_timeout_ignore: assert property (p_timeout_ignore)
        else $error("kick acted while output low");

    property p_window_kick;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == WWD_ST_WATCH && !disabled && kick_fall
         && cnt_reg >= lower_t) |=> (cnt_reg == '0 && timeout_output_n);
    endproperty
    a_window_kick: assert property (p_window_kick)
        else $error("kick inside window not accepted");
endmodule : wwd_top
`default_nettype wire

// [sim/wwd_kick_host.sv]
`timescale 1ns/1ps
`default_nettype none
module wwd_kick_host (
    // clock
    input  wire logic pclk,
    // kick line towards the watchdog
    output var logic  kick_input
);
    // driven at all times, never left floating
    initial kick_input = 1'b1;
    // falling edge n cycles after the call, released one cycle later
    task automatic kick(input int n);
        repeat (n) @(posedge pclk);
        kick_input <= 1'b0;
        @(posedge pclk);
        kick_input <= 1'b1;
    endtask : kick
endmodule : wwd_kick_host
`default_nettype wire

// [sim/wwd_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end
module wwd_tb_top;
    import wwd_pkg::*;
    // short counts keep the run small
    localparam int CU = 400, CL = 80, CD = 200, PU = 120, PL = 40;
    localparam int LU = 160, LL = 48, OD = 60, LD = 100;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, kick_input, timeout_output_n;
    int          mismatches = 0, check_count = 0, low_run = 0;
    int          high_run = 0, last_low = 0, last_high = 0, falls = 0, f;
    int          lo[3] = '{LL, PL / 2, CL / 4};
    int          up[3] = '{LU, PU, CU};
    int          dl[3] = '{LD, OD, LD};
    // sel, timeout strap and delay strap per entry
    logic [31:0] cfg[3] = '{32'h0000_0110, 32'h0000_0222, 32'h0000_0103};

    initial forever #12.5 pclk = ~pclk;

    wwd_top #(.CAP_UPPER(CU), .CAP_LOWER(CL), .CAP_DELAY(CD),
        .PRE_UPPER(PU), .PRE_LOWER(PL), .PULL_UPPER(LU),
        .PULL_LOWER(LL), .OPEN_DELAY(OD), .PULL_DELAY(LD)) wwd_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .kick_input(kick_input),
        .timeout_output_n(timeout_output_n));
    wwd_kick_host wwd_kick_host_inst (.pclk(pclk), .kick_input(kick_input));

    ////////////////////////////////////////////////////////////////////////
    // lengths of the last low pulse and of the high stretch before it
    always @(posedge pclk) begin
        if (timeout_output_n === 1'b0) begin
            if (low_run == 0) begin
                last_high = high_run;
                falls++;
            end
            low_run++;
            high_run = 0;
        end else begin
            if (low_run != 0) last_low = low_run;
            low_run = 0;
            high_run++;
        end
    end

    task automatic give_verdict();
        if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            mismatches++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // #1 lets the monitor finish the edge before results are read
    task automatic wait_out(input logic lvl, input int bound);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (timeout_output_n !== lvl && n < bound);
        `CHK(timeout_output_n, lvl);
        if (timeout_output_n !== lvl) give_verdict();
        #1;
    endtask : wait_out

    task automatic wait_state(input logic [1:0] st);
        int n;
        n = 0;
        do begin
            apb(1'b0, WWD_STATUS_OFS, 32'h0);
            n++;
        end while (rd[1:0] !== st && n < 200);
        `CHK(rd[1:0], st);
        if (rd[1:0] !== st) give_verdict();
    endtask : wait_state

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        wwd_kick_host_inst.kick(10);
        apb(1'b0, WWD_STATUS_OFS, 32'h0);
        `CHK(rd[1:0], WWD_ST_STARTUP);
        apb(1'b0, WWD_CTRL_OFS, 32'h0);
        `CHK(rd, WWD_CTRL_RST);
        apb(1'b1, 12'h00c, 32'hffff_ffff);
        `CHK(err, 1'b1);
        apb(1'b0, 12'h00c, 32'h0);
        `CHK(rd, 32'h0);
        wait_state(WWD_ST_WATCH);
        `CHK(falls, 0);
        repeat (3) wwd_kick_host_inst.kick(CD);
        `CHK(falls, 0);
        // missed window, then a kick while the output is low
        wait_out(1'b0, CU + 20);
        apb(1'b0, WWD_STATUS_OFS, 32'h0);
        `CHK(rd[3:0], 4'h7);
        wwd_kick_host_inst.kick(CD / 2);
        wait_out(1'b1, CD + 20);
        `CHK(last_low, CD);
        apb(1'b0, WWD_STATUS_OFS, 32'h0);
        `CHK(rd[5:4], 2'b10);
        wwd_kick_host_inst.kick(CL / 2);
        wait_out(1'b0, 20);
        wait_out(1'b1, CD + 20);
        `CHK(last_low, CD);
        apb(1'b0, WWD_STATUS_OFS, 32'h0);
        `CHK(rd[5:4], 2'b01);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, WWD_CTRL_OFS, cfg[i]);
            apb(1'b0, WWD_CTRL_OFS, 32'h0);
            `CHK(rd, cfg[i]);
            wait_out(1'b0, 2 * CU);
            wait_out(1'b1, 2 * CU);
            f = falls;
            wwd_kick_host_inst.kick(lo[i] + 6);
            // a wrongly refused kick shows low one edge later
            repeat (2) @(posedge pclk);
            #1;
            `CHK(falls, f);
            wwd_kick_host_inst.kick(lo[i] - 6);
            wait_out(1'b0, 20);
            wait_out(1'b1, 2 * CD);
            `CHK(last_low, dl[i]);
            wait_out(1'b0, up[i] + 20);
            `CHK(last_high, up[i]);
            wait_out(1'b1, 2 * CD);
            `CHK(last_low, dl[i]);
        end
        // disabled: kicks and silence both leave the output high
        apb(1'b1, WWD_CTRL_OFS, 32'h0000_0001);
        wait_state(WWD_ST_OFF);
        `CHK(rd[3], 1'b1);
        apb(1'b0, WWD_CNT_OFS, 32'h0);
        `CHK(rd, 32'h0);
        f = falls;
        repeat (4) wwd_kick_host_inst.kick(5);
        repeat (2 * CU) @(posedge pclk);
        `CHK(falls, f);
        `CHK(timeout_output_n, 1'b1);
        // mid-run reset: straps back to default, startup delay again
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        f = falls;
        wwd_kick_host_inst.kick(5);
        repeat (2) @(posedge pclk);
        #1;
        `CHK(falls, f);
        apb(1'b0, WWD_CTRL_OFS, 32'h0);
        `CHK(rd, WWD_CTRL_RST);
        apb(1'b0, WWD_STATUS_OFS, 32'h0);
        `CHK(rd[3:0], 4'h0);
        give_verdict();
    end
endmodule : wwd_tb_top
`default_nettype wire
